// ===== rtl/fsc_sweep_core.sv
/*
 fsc_sweep_core: frequency sweep engine, commands in, frequency word and
 trigger/sync levels out. Assumes commands arrive as one-cycle strobes from
 logic on i_core_clk and that i_trig_in is an asynchronous pin.
*/
// Overview of operation
// - begin frequency range, reset 100 Hz, direction
// - end frequency same range, reset 1 kHz
// - centre resets 550 Hz, capped by width
// - width is end minus begin, signed
// - caps for ramp and arbitrary waveforms
// - linear or logarithmic steps, linear default
// - sweep time 1 ms to 500 s
// - step count derived from sweep time
// - enabling sweep turns burst, modulation off
// - internal origin repeats, time plus 1 ms
// - one sweep per selected external edge
// - one sweep per software trigger, waiting shown
// - completion sets event bit or answers query
// - input edge polarity, rising default
// - trigger output edge at each sweep start
// - internal origin gives half-duty square output
// - external origin disables trigger output
// - software origin gives pulse over 1 us
// - marker high at start, low at marker
// - marker outside range clamped, conflict raised
// - marker overrides sync enable; else carrier sync
`timescale 1ns/100ps
module fsc_sweep_core #(
    parameter int P_STEP_CYCLES = fsc_pkg::STEP_CYCLES  // cycles in 1 ms
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_clk_en,
    input  wire fsc_pkg::fsc_cmd_type   i_cmd,
    input  wire fsc_pkg::fsc_wave_type  i_wave,
    input  wire logic                   i_trig_in,
    input  wire logic                   i_carrier_sync,
    output logic [fsc_pkg::FW-1:0]      o_cur_freq,
    output logic [fsc_pkg::FW-1:0]      o_begin_freq,
    output logic [fsc_pkg::FW-1:0]      o_end_freq,
    output logic                        o_sweeping,
    output logic                        o_waiting,
    output logic                        o_trig_out,
    output logic                        o_sync_out,
    output fsc_pkg::fsc_event_type      o_event
);
    import fsc_pkg::*;

    // clamp helper, shared by the begin, end, centre and marker settings
    function automatic logic [FW-1:0] clampf(input logic [FW:0] v,
                                            input logic [FW-1:0] lo,
                                            input logic [FW-1:0] hi);
        clampf = (v < {1'b0, lo}) ? lo : (v > {1'b0, hi}) ? hi : v[FW-1:0];
    endfunction : clampf

    localparam int MSW = $clog2(P_STEP_CYCLES + 1);
    localparam logic [MSW-1:0] MS_LAST = MSW'(P_STEP_CYCLES - 1);
    localparam logic [5:0] PULSE_LEN = 6'(PULSE_CYCLES);

    logic [FW-1:0]   f_begin;         // sweep_begin_frequency
    logic [FW-1:0]   f_end;           // sweep_end_frequency
    logic [FW-1:0]   f_marker;        // marker_frequency
    logic [DURW-1:0] dur_ms;          // sweep_duration
    logic            sweep_enable;
    logic            log_spacing;     // step_spacing_select
    logic            in_neg;          // input_edge_polarity, high = falling
    logic            out_neg;         // output_edge_polarity, high = falling
    logic            trig_out_en;     // trigger_output_enable
    logic            marker_en;
    logic            sync_en;         // sync_output_enable
    logic            opc_pending;     // completion query outstanding
    fsc_src_type     origin;          // trigger_origin_select
    fsc_state_type   state;
    fsc_state_type   next_state;
    logic [1:0]      trig_sync;       // [0] only feeds [1]
    logic            trig_prev;
    logic [MSW-1:0]  ms_cnt;
    logic [DURW-1:0] step_idx;
    logic [DW-1:0]   div_rem;
    logic [DW-1:0]   div_quo;
    logic [DW-1:0]   div_den;
    logic [6:0]      div_cnt;
    logic [5:0]      pulse_cnt;
    logic            mark_hi;

    // derived view of the end points
    wire signed [FW:0] width    = $signed({1'b0, f_end}) - $signed({1'b0, f_begin});
    wire        [FW:0] width_m  = width[FW] ? FW'(0) - width : width;
    wire        [FW:0] centre   = FW'(({1'b0, f_begin} + {1'b0, f_end}) >> 1);
    wire               going_up = !width[FW];
    wire [FW-1:0] f_lo = going_up ? f_begin : f_end;
    wire [FW-1:0] f_hi = going_up ? f_end : f_begin;

    // per-waveform ceiling
    wire [FW-1:0] f_max = (i_wave == WAVE_RAMP) ? F_MAX_RAMP :
                          (i_wave == WAVE_ARB)  ? F_MAX_ARB : F_MAX_STD;

    // command decode
    wire          cmd_on  = i_cmd.valid;
    wire [FW:0]   cd      = i_cmd.data;
    wire [FW-1:0] new_f   = clampf(cd, F_LOW, f_max);
    wire [FW-1:0] half_m  = FW'(width_m >> 1);
    wire [FW-1:0] c_new   = clampf(cd, half_m + F_LOW, f_max - half_m);
    wire [FW:0]   w_room  = (centre[FW-1:0] < f_max - centre[FW-1:0]) ?
                            centre - F_LOW : {1'b0, f_max} - centre;
    wire [FW:0]   w_req_m = cd[FW] ? FW'(0) - cd : cd;
    wire [FW:0]   w_cap_m = (w_req_m > (w_room << 1)) ? FW'(w_room << 1) : w_req_m;
    wire signed [FW:0] w_new = cd[FW] ? $signed(FW'(0) - w_cap_m)
                                      : $signed(w_cap_m);
    wire [FW-1:0] wb_new  = FW'($signed(centre) - (w_new >>> 1));
    wire [FW-1:0] cb_new  = FW'($signed({1'b0, c_new}) - (width >>> 1));
    wire [FW-1:0] mark_in = (cmd_on && i_cmd.op == OP_MARKER_F) ? new_f : f_marker;
    wire          mark_out = (mark_in < f_lo) || (mark_in > f_hi);
    wire [FW-1:0] mark_fix = (mark_in < f_lo) ? f_lo : (mark_in > f_hi) ? f_hi : mark_in;
    wire          en_write = cmd_on && i_cmd.op == OP_ENABLE;
    wire          mark_chk = sweep_enable && cmd_on && i_cmd.op == OP_MARKER_F ||
                             en_write && cd[0];
    wire          sw_trig  = cmd_on && i_cmd.op == OP_SW_TRIG;
    wire          opc_ask  = cmd_on && i_cmd.op == OP_QUICK_CFG && cd[1];

    // external edge on the second synchroniser stage only
    wire ext_edge = in_neg ? (trig_prev && !trig_sync[1])
                           : (!trig_prev && trig_sync[1]);
    wire go_trig  = (origin == SRC_EXTERNAL && ext_edge) ||
                    (origin == SRC_SOFTWARE && sw_trig);

    wire ms_tick   = (ms_cnt == MS_LAST);
    wire last_step = (step_idx == dur_ms - DURW'(1));
    wire done      = (state == ST_RUN) && ms_tick && last_step;
    wire div_done  = (div_cnt == DIV_STEPS);
    wire run_start = (state == ST_CALC) && div_done;

    // step size: equal increments or a fixed fractional growth
    wire [FW+DW-1:0] growth = o_cur_freq * div_quo;
    wire [FW-1:0] step_log = (|growth[FW+DW-1:FW+LOGQ]) ? {FW{1'b1}}
                                                        : growth[FW+LOGQ-1:LOGQ];
    wire [FW-1:0] step_amt = log_spacing ? step_log : div_quo[FW-1:0];
    wire [FW:0]   f_up     = {1'b0, o_cur_freq} + {1'b0, step_amt};
    wire [FW:0]   f_dn     = {1'b0, o_cur_freq} - {1'b0, step_amt};
    wire [FW-1:0] f_next   = last_step ? f_end :
                             going_up ? ((f_up >= {1'b0, f_end}) ? f_end : f_up[FW-1:0])
                                      : ((f_dn[FW] || f_dn[FW-1:0] <= f_end) ? f_end
                                                                 : f_dn[FW-1:0]);

    // divider operands latched on entry to the calculation
    wire [DW-1:0] num_ld = log_spacing ? (DW'(width_m) << LOGQ) : DW'(width_m);
    wire [DW-1:0] den_ld = log_spacing ? DW'(f_begin) * DW'(dur_ms) : DW'(dur_ms);
    wire [DW:0]   rem_sh = {div_rem, div_quo[DW-1]};
    wire          rem_ge = rem_sh >= {1'b0, div_den};
    wire [DW-1:0] rem_nx = rem_ge ? DW'(rem_sh - {1'b0, div_den}) : DW'(rem_sh);

    // output levels
    wire reached  = going_up ? (o_cur_freq >= f_marker) : (o_cur_freq <= f_marker);
    wire half_on  = (state == ST_RUN) && (step_idx < DURW'((dur_ms + DURW'(1)) >> 1));
    wire act_lvl  = (origin == SRC_INTERNAL) ? half_on :
                    (origin == SRC_SOFTWARE) ? (pulse_cnt != 6'h00) : 1'b0;
    wire next_trig = trig_out_en && origin != SRC_EXTERNAL &&
                     (act_lvl ^ out_neg);
    wire next_sync = (marker_en && sweep_enable) ? mark_hi
                                                 : (sync_en && i_carrier_sync);

    // sweep sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = (origin == SRC_INTERNAL) ? ST_CALC : ST_ARM;
            ST_ARM:  if (go_trig) next_state = ST_CALC;
            ST_CALC: if (div_done) next_state = ST_RUN;
            ST_RUN:  if (done) begin
                next_state = (origin == SRC_INTERNAL) ? ST_GAP : ST_ARM;
            end
            ST_GAP:  if (ms_tick) next_state = ST_CALC;
            default: next_state = ST_IDLE;
        endcase
        if (!sweep_enable) begin
            next_state = ST_IDLE;
        end
    end

    // settings, written by commands
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            f_begin <= BEGIN_RST;
            f_end <= END_RST;
            f_marker <= MARKER_RST;
            dur_ms <= DUR_RST;
            {sweep_enable, log_spacing, in_neg, out_neg} <= 4'h0;
            {trig_out_en, marker_en, sync_en} <= 3'h0;
            origin <= SRC_INTERNAL;
        end else if (i_clk_en && cmd_on) begin
            case (i_cmd.op)
                OP_BEGIN_FREQ: f_begin <= new_f;
                OP_END_FREQ:   f_end <= new_f;
                OP_CENTRE:     begin f_begin <= cb_new; f_end <= FW'(cb_new + width); end
                OP_WIDTH:      begin f_begin <= wb_new; f_end <= FW'(wb_new + w_new); end
                OP_SPACING:    log_spacing <= cd[0];
                OP_DURATION:   dur_ms <= (cd < DUR_MIN) ? DUR_MIN :
                                         (cd > DUR_MAX) ? DUR_MAX : cd[DURW-1:0];
                OP_ENABLE:     sweep_enable <= cd[0];
                OP_ORIGIN:     origin <= fsc_src_type'(cd[1:0]);
                OP_IN_POL:     in_neg <= cd[0];
                OP_OUT_POL:    out_neg <= cd[0];
                OP_TRIG_OUT:   trig_out_en <= cd[0];
                OP_MARKER_F:   f_marker <= new_f;
                OP_MARKER_EN:  marker_en <= cd[0];
                OP_SYNC_EN:    sync_en <= cd[0];
                OP_QUICK_CFG:  if (cd[0]) origin <= SRC_INTERNAL;
                default:       ;
            endcase
            if (mark_chk) begin
                f_marker <= mark_fix;
            end
        end
    end

    // state, counters and divider
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            {trig_sync, trig_prev} <= 3'h0;
            ms_cnt <= '0;
            step_idx <= '0;
            {div_rem, div_quo, div_den} <= '0;
            div_cnt <= 7'h00;
        end else if (i_clk_en) begin
            state <= next_state;
            trig_sync <= {trig_sync[0], i_trig_in};
            trig_prev <= trig_sync[1];
            ms_cnt <= (state == ST_RUN || state == ST_GAP) && !ms_tick ?
                      MSW'(ms_cnt + MSW'(1)) : '0;
            if (state == ST_RUN && ms_tick) begin
                step_idx <= DURW'(step_idx + DURW'(1));
            end else if (state != ST_RUN) begin
                step_idx <= '0;
            end
            if (next_state == ST_CALC && state != ST_CALC) begin
                {div_rem, div_quo, div_den, div_cnt} <= {DW'(0), num_ld, den_ld, 7'h00};
            end else if (state == ST_CALC && !div_done) begin
                div_rem <= rem_nx;
                div_quo <= {div_quo[DW-2:0], rem_ge};
                div_cnt <= div_cnt + 7'h01;
            end
        end
    end

    // outputs, all registered
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_cur_freq <= BEGIN_RST;
            {o_begin_freq, o_end_freq} <= {BEGIN_RST, END_RST};
            {o_sweeping, o_waiting, o_trig_out, o_sync_out} <= 4'h0;
            o_event <= '0;
            {opc_pending, mark_hi} <= 2'h0;
            pulse_cnt <= 6'h00;
        end else if (i_clk_en) begin
            o_begin_freq <= f_begin;
            o_end_freq <= f_end;
            if (state == ST_RUN && ms_tick) begin
                o_cur_freq <= f_next;
            end else if (state != ST_RUN) begin
                o_cur_freq <= f_begin;
            end
            o_sweeping <= (next_state == ST_RUN);
            o_waiting <= (next_state == ST_ARM) && origin == SRC_SOFTWARE;
            pulse_cnt <= run_start ? PULSE_LEN :
                         (pulse_cnt != 6'h00) ? pulse_cnt - 6'h01 : 6'h00;
            o_trig_out <= next_trig;
            mark_hi <= run_start ? 1'b1 :
                       (state == ST_RUN && reached) ? 1'b0 : mark_hi;
            o_sync_out <= next_sync;
            opc_pending <= opc_ask || (opc_pending && !done);
            o_event.opc_set <= done;
            o_event.opc_reply <= done && (opc_pending || opc_ask);
            o_event.conflict <= mark_chk && mark_out;
            o_event.modes_off <= en_write && cd[0];
        end
    end

    // checks beside the logic
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n || !i_clk_en);

    sequence s_armed_sw;
        state == ST_ARM && origin == SRC_SOFTWARE && sweep_enable;
    endsequence
    sequence s_sw_kick;
        s_armed_sw ##0 sw_trig;
    endsequence

    a_opc_on_done: assert property (done |=> o_event.opc_set)
        else $error("completion flag missing after sweep end");
    a_freq_ends_at: assert property (done |=> o_cur_freq == $past(f_end))
        else $error("sweep did not land on end frequency");
    a_modes_forced: assert property (en_write && cd[0] |=> o_event.modes_off)
        else $error("modes not forced off on sweep enable");
    a_ext_trig_off: assert property (origin == SRC_EXTERNAL |=> !o_trig_out)
        else $error("trigger output driven under external origin");
    a_sw_one_start: assert property (s_sw_kick |=> state == ST_CALC)
        else $error("software trigger did not start a sweep");
    a_sw_waiting: assert property (s_armed_sw ##1 s_armed_sw |-> o_waiting)
        else $error("waiting indication absent");
    a_ext_start: assert property (state == ST_ARM && origin == SRC_EXTERNAL &&
                                  sweep_enable && ext_edge |=> state == ST_CALC)
        else $error("external edge did not start a sweep");
    a_calc_bound: assert property (state == ST_CALC && div_cnt == 7'h00 && sweep_enable
                                   |-> ##[1:80] state == ST_RUN)
        else $error("step calculation overran");
    a_sw_pulse: assert property (run_start && origin == SRC_SOFTWARE && trig_out_en &&
                                 !out_neg && sweep_enable |=> ##1 o_trig_out [*8])
        else $error("software trigger pulse too short");
    a_marker_drop: assert property (marker_en && sweep_enable && state == ST_RUN &&
                                    reached && !run_start |=> ##1 !o_sync_out)
        else $error("sync did not drop at marker");
    a_marker_clamp: assert property (o_event.conflict |-> f_marker >= f_lo &&
                                     f_marker <= f_hi)
        else $error("marker left outside sweep range");
    a_gap_length: assert property ($rose(state == ST_GAP) |-> (state == ST_GAP) [*8])
        else $error("retrace gap ended early");
endmodule : fsc_sweep_core

// ===== inc/fsc_pkg.sv
/*
 fsc_pkg: constants, encodings and carriers for the frequency sweep core.
 Assumes a 40 MHz core clock; frequencies are unsigned counts of micro-hertz.
*/
package fsc_pkg;
    localparam int FW   = 48;                 // frequency width, micro-hertz
    localparam int DURW = 19;                 // sweep time width, milliseconds
    localparam int DW   = 72;                 // divider width
    localparam int LOGQ = 16;                 // log growth fraction bits
    localparam logic [FW-1:0] HZ = 48'h0F4240;        // one hertz in micro-hertz
    localparam logic [FW-1:0] F_LOW      = 48'h1;     // 1 micro-hertz floor
    localparam logic [FW-1:0] F_MAX_STD  = HZ * 48'h1312D00; // 20 MHz
    localparam logic [FW-1:0] F_MAX_RAMP = HZ * 48'h30D40;   // 200 kHz
    localparam logic [FW-1:0] F_MAX_ARB  = HZ * 48'h5B8D80;  // 6 MHz
    localparam logic [FW-1:0] BEGIN_RST  = HZ * 48'h64;      // 100 Hz
    localparam logic [FW-1:0] END_RST    = HZ * 48'h3E8;     // 1 kHz
    localparam logic [FW-1:0] MARKER_RST = HZ * 48'h1F4;     // 500 Hz
    localparam logic [DURW-1:0] DUR_RST  = 19'h003E8;        // 1 s in ms
    localparam logic [DURW-1:0] DUR_MIN  = 19'h00001;        // 1 ms
    localparam logic [DURW-1:0] DUR_MAX  = 19'h7A120;        // 500 s in ms
    localparam int CLK_HZ        = 40_000_000;
    localparam int STEP_TIME_NS  = 1_000_000;  // one step and the retrace gap
    localparam int PULSE_TIME_NS = 1_000;      // software trigger pulse, exceeded
    localparam int STEP_CYCLES   = (STEP_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int PULSE_CYCLES  = (PULSE_TIME_NS * (CLK_HZ / 1_000_000)) / 1000 + 1;
    localparam logic [6:0] DIV_STEPS = 7'h48;  // one divider bit per cycle

    typedef enum logic [1:0] {
        WAVE_SINE = 2'h0, WAVE_SQUARE = 2'h1, WAVE_RAMP = 2'h2, WAVE_ARB = 2'h3
    } fsc_wave_type;

    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'h0, SRC_EXTERNAL = 2'h1, SRC_SOFTWARE = 2'h2
    } fsc_src_type;

    typedef enum logic [3:0] {
        OP_BEGIN_FREQ  = 4'h0, OP_END_FREQ  = 4'h1, OP_CENTRE   = 4'h2,
        OP_WIDTH       = 4'h3, OP_SPACING   = 4'h4, OP_DURATION = 4'h5,
        OP_ENABLE      = 4'h6, OP_ORIGIN    = 4'h7, OP_IN_POL   = 4'h8,
        OP_OUT_POL     = 4'h9, OP_TRIG_OUT  = 4'hA, OP_MARKER_F = 4'hB,
        OP_MARKER_EN   = 4'hC, OP_SYNC_EN   = 4'hD, OP_SW_TRIG  = 4'hE,
        OP_QUICK_CFG   = 4'hF
    } fsc_op_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_ARM = 3'h1, ST_CALC = 3'h3, ST_RUN = 3'h2, ST_GAP = 3'h6
    } fsc_state_type;

    typedef struct packed {
        logic         valid;   // one-cycle command strobe
        fsc_op_type   op;      // what to change
        logic [FW:0]  data;    // value; signed for the width
    } fsc_cmd_type;

    typedef struct packed {
        logic opc_set;         // completion, bit 0 of the event status
        logic opc_reply;       // answer 1 to a pending completion query
        logic conflict;        // marker was clamped
        logic modes_off;       // burst and modulation must switch off
    } fsc_event_type;
endpackage : fsc_pkg

// ===== verif/fsc_host_model.sv
/*
 fsc_host_model: host command source and external trigger source for the sweep core.
 Assumes the bench calls its tasks; all changes land just after a falling edge.
*/
`timescale 1ns/100ps
module fsc_host_model (
    input  wire logic            i_core_clk,
    output fsc_pkg::fsc_cmd_type o_cmd,
    output logic                 o_trig
);
    import fsc_pkg::*;
    initial begin
        o_cmd  = '0;        // no strobe before the first command
        o_trig = 1'b0;      // trigger pin idles low
    end
    // one-cycle strobe, then a spare edge so end points have settled on return
    task automatic send(input fsc_op_type op, input logic [FW:0] data);
        @(negedge i_core_clk);
        o_cmd = '{1'b1, op, data};
        @(negedge i_core_clk);
        o_cmd.valid = 1'b0;
        @(negedge i_core_clk);
    endtask : send
    // one edge of the asked direction; caller spaces edges past the sweep
    task automatic edge_in(input logic rising);
        @(negedge i_core_clk);
        o_trig = ~rising;
        repeat (4) @(negedge i_core_clk);
        o_trig = rising;
    endtask : edge_in
endmodule : fsc_host_model

// ===== verif/fsc_sweep_core_bench.sv
/*
 fsc_sweep_core_bench: self-checking bench for the sweep core.
 Assumes a 20-cycle step parameter and the host model as command and trigger source.
*/
`timescale 1ns/100ps
module fsc_sweep_core_bench;
    import fsc_pkg::*;
    localparam int STEP = 20;           // short step keeps each sweep brief
    logic          i_core_clk = 1'b0;
    logic          rst_n      = 1'b0;
    logic          carrier    = 1'b0;   // stand-in for the carrier sync
    fsc_wave_type  wave       = WAVE_SINE;
    fsc_cmd_type   cmd;
    logic          trig;
    logic [FW-1:0] cur, bf, ef, prev_cur, end_seen;
    logic          sweeping, waiting, trig_out, sync_out, prev_run;
    fsc_event_type ev;
    int num_errors = 0, comparisons = 0, n_start = 0, n_opc = 0, n_conf = 0, n_off = 0;
    int n_rep = 0;                       // completion query answers seen
    always #12.5 i_core_clk = ~i_core_clk;  // 40 MHz
    fsc_host_model host (.i_core_clk(i_core_clk), .o_cmd(cmd), .o_trig(trig));
    fsc_sweep_core #(.P_STEP_CYCLES(STEP)) dut (.i_core_clk(i_core_clk), .i_reset_n(rst_n),
        .i_clk_en(1'b1), .i_cmd(cmd), .i_wave(wave), .i_trig_in(trig),
        .i_carrier_sync(carrier), .o_cur_freq(cur), .o_begin_freq(bf), .o_end_freq(ef),
        .o_sweeping(sweeping), .o_waiting(waiting), .o_trig_out(trig_out),
        .o_sync_out(sync_out), .o_event(ev));
    // events counted at the falling edge, where register outputs have settled
    always @(negedge i_core_clk) begin
        if (sweeping === 1'b1 && prev_run !== 1'b1) n_start++;
        if (ev.opc_set === 1'b1) begin
            n_opc++;
            end_seen = cur;         // landing frequency, loaded on the completion edge
        end
        if (ev.opc_reply === 1'b1) n_rep++;
        if (ev.conflict === 1'b1) n_conf++;
        if (ev.modes_off === 1'b1) n_off++;
        prev_run = sweeping;
        prev_cur = cur;
    end
    function automatic logic [FW:0] hz(input logic [FW-1:0] n);
        return {1'b0, HZ * n};
    endfunction : hz
    task automatic test_done;
        $display("counts: comparisons=%0d mismatches=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [FW-1:0] got, input logic [FW-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // bounded wait on an event counter; a miss ends the run
    task automatic wait_cnt(ref int c, input int goal, input int lim);
        int n;
        n = 0;
        while (c < goal && n < lim) begin
            @(negedge i_core_clk);
            n++;
        end
        chk(48'(c >= goal), 48'h1);
        if (c < goal) test_done();
    endtask : wait_cnt
    task automatic t_limits;
        chk(bf, BEGIN_RST);
        chk(ef, END_RST);
        chk(48'(trig_out), 48'h0);
        wave = WAVE_RAMP;
        host.send(OP_BEGIN_FREQ, 49'h0);
        chk(bf, F_LOW);
        host.send(OP_END_FREQ, hz(48'h1312D00));
        chk(ef, F_MAX_RAMP);
        wave = WAVE_ARB;
        host.send(OP_END_FREQ, hz(48'h1312D00));
        chk(ef, F_MAX_ARB);
        wave = WAVE_SINE;
        host.send(OP_END_FREQ, hz(48'h1312D01));
        chk(ef, F_MAX_STD);
        host.send(OP_BEGIN_FREQ, hz(48'h64));
        host.send(OP_END_FREQ, hz(48'h3E8));
        host.send(OP_WIDTH, 49'h0 - hz(48'h384));
        chk(bf, END_RST);
        host.send(OP_WIDTH, hz(48'h384));
        chk(bf, BEGIN_RST);
        $display("test limits done");
    endtask : t_limits
    task automatic t_soft;
        host.send(OP_DURATION, 49'h3);
        host.send(OP_ORIGIN, 49'h2);
        host.send(OP_TRIG_OUT, 49'h1);
        host.send(OP_ENABLE, 49'h1);
        chk(48'(n_off), 48'h1);
        chk(48'(waiting), 48'h1);
        host.send(OP_QUICK_CFG, 49'h2);
        host.send(OP_SW_TRIG, 49'h0);
        wait_cnt(n_start, 1, 200);
        repeat (3) @(negedge i_core_clk);
        chk(48'(trig_out), 48'h1);
        repeat (34) @(negedge i_core_clk);
        chk(48'(trig_out), 48'h1);
        wait_cnt(n_opc, 1, 200);
        chk(end_seen, END_RST);
        chk(48'(n_rep), 48'h1);
        chk(48'(n_start), 48'h1);
        $display("test software trigger done");
    endtask : t_soft
    task automatic t_ext;
        host.send(OP_ORIGIN, 49'h1);
        chk(48'(trig_out), 48'h0);
        host.edge_in(1'b1);
        wait_cnt(n_start, 2, 120);
        wait_cnt(n_opc, 2, 200);
        host.send(OP_IN_POL, 49'h1);
        host.edge_in(1'b0);
        wait_cnt(n_start, 3, 120);
        host.send(OP_MARKER_EN, 49'h1);
        host.send(OP_MARKER_F, hz(48'hA));
        wait_cnt(n_conf, 1, 8);
        host.send(OP_MARKER_F, hz(48'h1F4));
        chk(48'(n_conf), 48'h1);
        $display("test external trigger done");
    endtask : t_ext
    task automatic t_int;
        host.send(OP_ENABLE, 49'h0);
        host.send(OP_ORIGIN, 49'h0);
        host.send(OP_ENABLE, 49'h1);
        wait_cnt(n_start, 4, 200);
        repeat (3) @(negedge i_core_clk);
        chk(48'(trig_out), 48'h1);
        chk(48'(sync_out), 48'h1);
        repeat (50) @(negedge i_core_clk);
        chk(48'(trig_out), 48'h0);
        chk(48'(sync_out), 48'h0);
        wait_cnt(n_start, 5, 200);
        host.send(OP_MARKER_EN, 49'h0);
        host.send(OP_SYNC_EN, 49'h1);
        carrier = 1'b1;
        repeat (2) @(negedge i_core_clk);
        chk(48'(sync_out), 48'h1);
        $display("test internal trigger done");
    endtask : t_int
    // reset for 20 cycles, then the scenarios in order
    initial begin
        repeat (20) @(negedge i_core_clk);
        rst_n = 1'b1;
        @(negedge i_core_clk);
        t_limits();
        t_soft();
        t_ext();
        t_int();
        test_done();
    end
endmodule : fsc_sweep_core_bench
